// >>> logic/pmg_bank.sv
// fixed-feature event/control register bank with two register blocks
`timescale 1ns/1ps
`include "pmg_params.svh"
// Summary of operation
// - high event input sets its status bit
// - writing one clears status; zero does nothing
// - enable never affects status set or clear
// - event output is status and enable
// - reserved bits read zero, writes ignored
// - each bit lives in block A, B or both
// - sleep type 0-7, separate per block
// - registers reachable in the I/O space
// - implemented fixed features behave exactly as defined
// - power button held four seconds forces off
// - mode select bit shows legacy or OS mode
// - alarm wakes the system from sleep
// - sleep entry and wake back to working
// - power and sleep buttons are fixed events
// - controller events belong in general event block
// - mode clear routes to firmware, set to OS
// - write-only bits act on a written one
module pmg_bank
    import pmg_pkg::*;
#(
    parameter int unsigned OVR_CYC = `PMG_OVR_CYC
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    // avalon-mm slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    // hardware events
    input  wire logic        i_pwr_button,
    input  wire logic        i_slp_button,
    input  wire logic        i_rtc_alarm,
    // interrupts and power control
    output logic             o_os_visible_event_interrupt,
    output logic             o_transparent_firmware_interrupt,
    output logic             o_sleep_req,
    output logic [2:0]       o_sleep_type_block_a,
    output logic [2:0]       o_sleep_type_block_b,
    output logic             o_sleeping,
    output logic             o_power_off
);
    // ============================================================
    // bus decode
    localparam int NE = `PMG_NUM_EVT;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    wire  [3:0]  idx    = i_avs_address[5:2];
    wire         req    = (i_avs_read | i_avs_write) & ~ack_r;
    wire         wr_go  = i_avs_write & ~ack_r;
    wire         be_lo  = i_avs_byteenable[0];
    wire         be_hi  = i_avs_byteenable[1];

    function automatic logic hit(input logic [3:0] a, input logic [3:0] want);
        hit = (a == want);
    endfunction

    wire wr_sts_a = wr_go & hit(idx, `PMG_IDX_STS_A);
    wire wr_en_a  = wr_go & hit(idx, `PMG_IDX_EN_A);
    wire wr_sts_b = wr_go & hit(idx, `PMG_IDX_STS_B);
    wire wr_en_b  = wr_go & hit(idx, `PMG_IDX_EN_B);
    wire wr_cnt_a = wr_go & hit(idx, `PMG_IDX_CNT_A) & be_lo & be_hi;
    wire wr_cnt_b = wr_go & hit(idx, `PMG_IDX_CNT_B) & be_lo & be_hi;

    // ============================================================
    // event cells, one per implemented (bit, block) pair
    logic [NE-1:0] evt_in;
    logic [NE-1:0] sts_a;
    logic [NE-1:0] en_a;
    logic [NE-1:0] out_a;
    logic [NE-1:0] sts_b;
    logic [NE-1:0] en_b;
    logic [NE-1:0] out_b;
    logic          wake_evt;
    localparam logic [NE-1:0] IN_A = `PMG_EVT_IN_A;
    localparam logic [NE-1:0] IN_B = `PMG_EVT_IN_B;

    // buttons and alarm are fixed events
    assign evt_in[`PMG_BIT_PWRBTN] = i_pwr_button;
    assign evt_in[`PMG_BIT_SLPBTN] = i_slp_button;
    assign evt_in[`PMG_BIT_RTC]    = i_rtc_alarm;
    assign evt_in[`PMG_BIT_WAKE]   = wake_evt;

    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_evt
            // bit position is fixed; the block holding it is a strap
            if (IN_A[g]) begin : g_a
                pmg_evt_cell u_cell (
                    .i_clk       (i_clk),
                    .i_resetn    (i_resetn),
                    .i_event     (evt_in[g]),
                    .i_clr       (wr_sts_a & be_lo & i_avs_writedata[g]),
                    .i_en_wr     (wr_en_a & be_lo),
                    .i_en_val    (i_avs_writedata[g]),
                    .o_status    (sts_a[g]),
                    .o_enable    (en_a[g]),
                    .o_event_out (out_a[g])
                );
            end else begin : g_na
                assign sts_a[g] = 1'b0;
                assign en_a[g]  = 1'b0;
                assign out_a[g] = 1'b0;
            end
            if (IN_B[g]) begin : g_b
                pmg_evt_cell u_cell (
                    .i_clk       (i_clk),
                    .i_resetn    (i_resetn),
                    .i_event     (evt_in[g]),
                    .i_clr       (wr_sts_b & be_lo & i_avs_writedata[g]),
                    .i_en_wr     (wr_en_b & be_lo),
                    .i_en_val    (i_avs_writedata[g]),
                    .o_status    (sts_b[g]),
                    .o_enable    (en_b[g]),
                    .o_event_out (out_b[g])
                );
            end else begin : g_nb
                assign sts_b[g] = 1'b0;
                assign en_b[g]  = 1'b0;
                assign out_b[g] = 1'b0;
            end
        end
    endgenerate

    // ============================================================
    // control bits: mode select and sleep type live in both blocks
    logic       mode_r;
    logic [2:0] slp_a_r;
    logic [2:0] slp_b_r;
    logic       slp_go_a_r;
    logic       slp_go_b_r;

    // sleep type is a plain 3-bit value, one per block
    wire [2:0] slp_wd = i_avs_writedata[`PMG_CNT_SLP_MSB:`PMG_CNT_SLP_LSB];
    wire       mode_wd = i_avs_writedata[`PMG_CNT_MODE];
    // sleep enable is write-only: a one pulses, a zero does nothing
    wire       go_a_nxt = wr_cnt_a & i_avs_writedata[`PMG_CNT_SLP_EN];
    wire       go_b_nxt = wr_cnt_b & i_avs_writedata[`PMG_CNT_SLP_EN];
    wire       mode_nxt = (wr_cnt_a | wr_cnt_b) ? mode_wd : mode_r;
    wire [2:0] slp_a_nxt = wr_cnt_a ? slp_wd : slp_a_r;
    wire [2:0] slp_b_nxt = wr_cnt_b ? slp_wd : slp_b_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_r     <= 1'b0;
            slp_a_r    <= `PMG_RST_SLP;
            slp_b_r    <= `PMG_RST_SLP;
            slp_go_a_r <= 1'b0;
            slp_go_b_r <= 1'b0;
        end else begin
            mode_r     <= mode_nxt;
            slp_a_r    <= slp_a_nxt;
            slp_b_r    <= slp_b_nxt;
            slp_go_a_r <= go_a_nxt;
            slp_go_b_r <= go_b_nxt;
        end
    end

    // ============================================================
    // event routing: shared events go to firmware until the OS takes over
    wire any_evt = |(out_a | out_b);
    assign o_os_visible_event_interrupt     = any_evt & mode_r;
    assign o_transparent_firmware_interrupt = any_evt & ~mode_r;

    // ============================================================
    // power button override: a long hold forces off regardless of software
    logic [31:0] hold_r;
    wire  [31:0] hold_nxt = !i_pwr_button ? 32'h0 :
                            (hold_r >= OVR_CYC) ? hold_r : hold_r + 32'h1;
    wire         ovr_hit  = i_pwr_button & (hold_r >= OVR_CYC - 1);

    // ============================================================
    // sleep/wake sequencer
    pmg_state_t st_r;
    pmg_state_t st_nxt;
    wire sleep_go = slp_go_a_r | slp_go_b_r;
    // alarm or either button wakes from sleep, enabled or not
    wire wake_src = i_rtc_alarm | i_pwr_button | i_slp_button;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            PMG_WORKING:  if (sleep_go) st_nxt = PMG_ENTER;
            PMG_ENTER:    st_nxt = PMG_SLEEPING;
            PMG_SLEEPING: if (wake_src) st_nxt = PMG_WORKING;
            PMG_OFF:      if (i_pwr_button & ~ovr_hit & (hold_r == 32'h0)) st_nxt = PMG_WORKING;
        endcase
        if (ovr_hit) st_nxt = PMG_OFF;
    end

    assign wake_evt = (st_r == PMG_SLEEPING) & wake_src;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r   <= PMG_WORKING;
            hold_r <= 32'h0;
        end else begin
            st_r   <= st_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign o_sleep_req          = (st_r == PMG_ENTER);
    assign o_sleeping           = (st_r == PMG_SLEEPING);
    assign o_power_off          = (st_r == PMG_OFF);
    assign o_sleep_type_block_a = slp_a_r;
    assign o_sleep_type_block_b = slp_b_r;

    // ============================================================
    // read mux; unmapped words and reserved bits return zero
    // controller events belong to the general event block, never mapped here
    wire [31:0] cnt_a_rd = {18'h0, 1'b0, slp_a_r, 9'h0, mode_r};
    wire [31:0] cnt_b_rd = {18'h0, 1'b0, slp_b_r, 9'h0, mode_r};

    always_comb begin
        rdata_nxt = 32'h0;
        unique case (idx)
            `PMG_IDX_STS_A: rdata_nxt = {{(32-NE){1'b0}}, sts_a};
            `PMG_IDX_EN_A:  rdata_nxt = {{(32-NE){1'b0}}, en_a};
            `PMG_IDX_STS_B: rdata_nxt = {{(32-NE){1'b0}}, sts_b};
            `PMG_IDX_EN_B:  rdata_nxt = {{(32-NE){1'b0}}, en_b};
            `PMG_IDX_CNT_A: rdata_nxt = cnt_a_rd;
            `PMG_IDX_CNT_B: rdata_nxt = cnt_b_rd;
            default:        rdata_nxt = 32'h0;
        endcase
    end

    // ============================================================
    // one wait cycle on every access; data registered on the answer edge
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r   <= req;
            rdata_r <= (req & i_avs_read) ? rdata_nxt : rdata_r;
        end
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign o_avs_readdata    = rdata_r;
endmodule

// >>> logic/pmg_evt_cell.sv
// one status/enable event cell
`timescale 1ns/1ps
module pmg_evt_cell (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // event and software access
    input  wire logic i_event,
    input  wire logic i_clr,
    input  wire logic i_en_wr,
    input  wire logic i_en_val,
    // cell state
    output logic      o_status,
    output logic      o_enable,
    output logic      o_event_out
);
    logic status_r;
    logic enable_r;
    logic status_nxt;
    logic enable_nxt;

    // set wins over a same-cycle clear; enable plays no part here
    assign status_nxt = i_event | (status_r & ~i_clr);
    assign enable_nxt = i_en_wr ? i_en_val : enable_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            status_r <= 1'b0;
            enable_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            enable_r <= enable_nxt;
        end
    end

    assign o_status    = status_r;
    assign o_enable    = enable_r;
    assign o_event_out = status_r & enable_r;
endmodule

// >>> logic/pmg_params.svh
// constants for the power-management event and control register bank
`ifndef PMG_PARAMS_SVH
`define PMG_PARAMS_SVH
// ============================================================
// register word indices (byte address = 4 * index)
`define PMG_IDX_STS_A      4'h0
`define PMG_IDX_EN_A       4'h1
`define PMG_IDX_STS_B      4'h2
`define PMG_IDX_EN_B       4'h3
`define PMG_IDX_CNT_A      4'h4
`define PMG_IDX_CNT_B      4'h5
// ============================================================
// status / enable bit positions (fixed for the whole grouping)
`define PMG_BIT_PWRBTN     0
`define PMG_BIT_SLPBTN     1
`define PMG_BIT_RTC        2
`define PMG_BIT_WAKE       3
`define PMG_NUM_EVT        4
// which block implements each event bit (1 = present)
`define PMG_EVT_IN_A       4'h7
`define PMG_EVT_IN_B       4'h8
// ============================================================
// control register fields
`define PMG_CNT_MODE       0
`define PMG_CNT_SLP_LSB    10
`define PMG_CNT_SLP_MSB    12
`define PMG_CNT_SLP_EN     13
// ============================================================
// reset values
`define PMG_RST_STS        4'h0
`define PMG_RST_EN         4'h0
`define PMG_RST_SLP        3'h0
// ============================================================
// timing
`define PMG_CLK_MHZ        100
`define PMG_OVR_SEC        4
`define PMG_OVR_CYC        (`PMG_OVR_SEC * `PMG_CLK_MHZ * 1000000)
`define PMG_WAKE_SEL       3'h0
`endif

// >>> logic/pmg_pkg.sv
// types for the power-management event and control register bank
package pmg_pkg;
    // ============================================================
    // power sequencing states
    typedef enum logic [1:0] {
        PMG_WORKING,
        PMG_ENTER,
        PMG_SLEEPING,
        PMG_OFF
    } pmg_state_t;
endpackage

// >>> tb/pmg_bank_monitor.sv
// concurrent checks on the ports of the power-management register bank
`timescale 1ns/1ps
`include "pmg_params.svh"
module pmg_bank_monitor #(
    parameter int unsigned OVR_CYC = 20
) (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic [5:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_pwr_button,
    input wire logic        i_slp_button,
    input wire logic        i_rtc_alarm,
    input wire logic        o_os_visible_event_interrupt,
    input wire logic        o_transparent_firmware_interrupt,
    input wire logic        o_sleep_req,
    input wire logic [2:0]  o_sleep_type_block_a,
    input wire logic        o_sleeping,
    input wire logic        o_power_off
);
    // ============================================================
    // helpers
    int unsigned hold_r;
    wire ev_any  = i_pwr_button | i_slp_button | i_rtc_alarm;
    wire irq_any = o_os_visible_event_interrupt | o_transparent_firmware_interrupt;
    wire cnt_a_wr = i_avs_write && !o_avs_waitrequest && i_avs_address[5:2] == `PMG_IDX_CNT_A;
    // consecutive cycles the power button has been held
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) hold_r <= 0;
        else hold_r <= i_pwr_button ? hold_r + 1 : 0;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // ============================================================
    // assertions
    chk_wait_answer: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus request not answered next cycle");
    chk_hole_zero: assert property (
        i_avs_read && !o_avs_waitrequest && i_avs_address[5:2] > `PMG_IDX_CNT_B
        |-> o_avs_readdata == 32'h0) else $error("hole read nonzero");
    chk_irq_route: assert property (
        !(o_os_visible_event_interrupt && o_transparent_firmware_interrupt))
        else $error("both interrupts high");
    chk_irq_cause: assert property (
        $rose(irq_any) |-> $past(ev_any) || $past(ev_any, 2) || $past(i_avs_write))
        else $error("interrupt without cause");
    chk_irq_hold: assert property (
        $fell(irq_any) |-> $past(i_avs_write))
        else $error("interrupt dropped without write");
    chk_sleep_pulse: assert property (
        o_sleep_req |=> !o_sleep_req && o_sleeping)
        else $error("sleep request not one cycle then sleeping");
    chk_wake_return: assert property (
        o_sleeping && ev_any |=> !o_sleeping)
        else $error("no wake after event");
    // the button has been sampled high for the full count: off must already stand
    chk_override_off: assert property (
        hold_r == OVR_CYC |-> o_power_off)
        else $error("held button did not force off");
    chk_type_a_load: assert property (
        cnt_a_wr && &i_avs_byteenable[1:0]
        |=> o_sleep_type_block_a == $past(i_avs_writedata[`PMG_CNT_SLP_MSB:`PMG_CNT_SLP_LSB]))
        else $error("type a wrong");
    cover property (o_sleeping ##1 !o_sleeping);
    cover property ($rose(o_power_off));
    cover property ($rose(o_os_visible_event_interrupt));
    cover property (o_sleep_req);
endmodule
bind pmg_bank pmg_bank_monitor #(.OVR_CYC(OVR_CYC)) u_mon (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_pwr_button(i_pwr_button),
    .i_slp_button(i_slp_button), .i_rtc_alarm(i_rtc_alarm),
    .o_os_visible_event_interrupt(o_os_visible_event_interrupt),
    .o_transparent_firmware_interrupt(o_transparent_firmware_interrupt),
    .o_sleep_req(o_sleep_req), .o_sleep_type_block_a(o_sleep_type_block_a),
    .o_sleeping(o_sleeping), .o_power_off(o_power_off));

// >>> tb/tb.sv
// self-checking bench for the power-management register bank
`timescale 1ns/1ps
`include "pmg_params.svh"
module tb;
    localparam int unsigned OVR = 20;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [5:0]  adr = 6'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'hf;
    logic [2:0]  ev = 3'h0;
    logic [31:0] rdat, rv, rva;
    logic        wreq, os_irq, fw_irq, slp_req, slping, off;
    logic [2:0]  sta, stb;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;
    pmg_bank #(.OVR_CYC(OVR)) uut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
        .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .i_pwr_button(ev[0]), .i_slp_button(ev[1]), .i_rtc_alarm(ev[2]),
        .o_os_visible_event_interrupt(os_irq), .o_transparent_firmware_interrupt(fw_irq),
        .o_sleep_req(slp_req), .o_sleep_type_block_a(sta), .o_sleep_type_block_b(stb),
        .o_sleeping(slping), .o_power_off(off));
    always #5 i_clk = ~i_clk;
    // ============================================================
    // tasks
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d,
                       input logic [3:0] b);
        @(posedge i_clk);
        adr <= {idx, 2'b00};
        wdat <= d;
        be <= b;
        rd <= !w;
        wr <= w;
        // waitrequest and read data are taken at the rising edge, as the slave sees them
        do @(posedge i_clk); while (wreq);
        rv = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wrr(input logic [3:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, 4'hf);
    endtask
    task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, 4'hf);
        check(rv, exp);
    endtask
    task automatic irqchk(input logic [1:0] e);
        @(negedge i_clk);
        check({30'h0, os_irq, fw_irq}, {30'h0, e});
    endtask
    task automatic pulse(input logic [2:0] e, input int n);
        @(posedge i_clk);
        ev <= e;
        repeat (n) @(posedge i_clk);
        ev <= 3'h0;
    endtask
    // hang guard: sized well above the expected run of a few hundred cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        // blocks are found only by their fixed word indices
        for (int i = 0; i < 16; i++) begin
            if (i > 5) wrr(4'(i), 32'hffffffff);
            rdchk(4'(i), 32'h0);
        end
        pulse(3'h7, 2);
        rdchk(`PMG_IDX_STS_A, 32'h7);
        irqchk(2'b00);
        wrr(`PMG_IDX_STS_A, 32'h0);
        rdchk(`PMG_IDX_STS_A, 32'h7);
        wrr(`PMG_IDX_STS_A, 32'hfffffff2);
        rdchk(`PMG_IDX_STS_A, 32'h5);
        wrr(`PMG_IDX_EN_A, 32'hffffffff);
        rdchk(`PMG_IDX_EN_A, 32'h7);
        irqchk(2'b01);
        wrr(`PMG_IDX_CNT_A, 32'h1);
        irqchk(2'b10);
        rdchk(`PMG_IDX_CNT_B, 32'h1);
        wrr(`PMG_IDX_EN_A, 32'h0);
        irqchk(2'b00);
        rdchk(`PMG_IDX_STS_A, 32'h5);
        wrr(`PMG_IDX_EN_A, 32'h7);
        wrr(`PMG_IDX_STS_A, 32'h1);
        irqchk(2'b10);
        wrr(`PMG_IDX_STS_A, 32'h4);
        irqchk(2'b00);
        pulse(3'h4, 1);
        // event lands on the same edge as the clearing write
        fork
            wrr(`PMG_IDX_STS_A, 32'h4);
            pulse(3'h4, 1);
        join
        rdchk(`PMG_IDX_STS_A, 32'h4);
        wrr(`PMG_IDX_STS_A, 32'h7);
        // all other bits equal in both writes; sleep type is judged on the pins, never read back
        for (int v = 0; v < 8; v++) begin
            wrr(`PMG_IDX_CNT_A, {19'h0, 3'(v), 10'h1});
            wrr(`PMG_IDX_CNT_B, {19'h0, 3'(7 - v), 10'h1});
            check({26'h0, sta, stb}, {26'h0, 3'(v), 3'(7 - v)});
        end
        bus(1'b1, `PMG_IDX_CNT_A, 32'h0c01, 4'h1);
        check({29'h0, sta}, 32'h7);
        wrr(`PMG_IDX_CNT_A, 32'h2001);
        for (int k = 0; k < 10 && !slping; k++) @(negedge i_clk);
        check({31'h0, slping}, 32'h1);
        rdchk(`PMG_IDX_CNT_A, 32'h1);
        pulse(3'h4, 1);
        repeat (2) @(negedge i_clk);
        check({31'h0, slping}, 32'h0);
        rdchk(`PMG_IDX_STS_A, 32'h4);
        rva = rv;
        rdchk(`PMG_IDX_STS_B, 32'h8);
        check(rva | rv, 32'hc);
        pulse(3'h1, OVR + 4);
        @(negedge i_clk);
        check({31'h0, off}, 32'h1);
        repeat (2) @(posedge i_clk);
        pulse(3'h1, 2);
        repeat (4) @(negedge i_clk);
        check({31'h0, off}, 32'h0);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        rdchk(`PMG_IDX_EN_A, 32'h0);
        rdchk(`PMG_IDX_STS_A, 32'h0);
        print_verdict();
    end
endmodule
